// ==== adc_dsp_pkg.sv ====
// constants, field layouts and carrier types for the adc output processing path
`default_nettype none
package adc_dsp_pkg;

    // register addresses on the configuration port
    localparam logic [7:0] ADDR_GAIN_OFFSET_LATENCY = 8'h1A;
    localparam logic [7:0] ADDR_FILTER_DECIMATION = 8'h1B;

    // field positions in gain_offset_latency_ctrl
    localparam int BYPASS_FAST_PATH_BIT = 7;
    localparam int DC_WINDOW_MSB = 6;
    localparam int DC_WINDOW_LSB = 4;
    localparam int FINE_TRIM_MSB = 3;
    localparam int FINE_TRIM_LSB = 0;

    // field positions in filter_decimation_ctrl
    localparam int DC_REMOVAL_ON_BIT = 7;
    localparam int COEF_SOURCE_BIT = 5;
    localparam int FIR_ACTIVE_BIT = 4;
    localparam int TAP_PARITY_BIT = 3;
    localparam int DOWNSAMPLE_MSB = 2;
    localparam int DOWNSAMPLE_LSB = 0;

    // reset values: processing off, zero trim, default window code
    localparam logic [3:0] FINE_TRIM_RESET = 4'h0;
    localparam logic [3:0] FINE_TRIM_MAX = 4'hA;
    localparam logic [2:0] DC_WINDOW_RESET = 3'h0;
    localparam logic [2:0] DOWNSAMPLE_RESET = 3'h0;

    // downsample_factor encodings
    localparam logic [2:0] DEC_BY_2 = 3'h0;
    localparam logic [2:0] DEC_BY_4 = 3'h1;
    localparam logic [2:0] DEC_NONE = 3'h3;
    localparam logic [2:0] DEC_BY_8 = 3'h4;

    // averaging window exponents in sample clocks
    localparam logic [4:0] DC_SHIFT_24 = 5'h18;
    localparam logic [4:0] DC_SHIFT_25 = 5'h19;
    localparam logic [4:0] DC_SHIFT_26 = 5'h1A;
    localparam logic [4:0] DC_SHIFT_27 = 5'h1B;
    localparam logic [4:0] DC_SHIFT_28 = 5'h1C;
    localparam logic [4:0] DC_SHIFT_29 = 5'h1D;

    // widths and depths
    localparam int SAMPLE_W = 14;
    localparam int COEF_W = 12;
    localparam int NUM_TAPS = 24;
    localparam int DC_ACC_W = 44;
    localparam int FIR_SUM_W = 32;
    localparam int COEF_FRAC = 10;
    localparam int GAIN_FRAC = 15;

    // latency of the fast bypass path, input port to output register
    localparam int LOW_LAT_CYCLES = 10;
    localparam int LOW_LAT_DEPTH = LOW_LAT_CYCLES - 1;

    // fine gain multipliers, unsigned Q1.15, one per 0.05 dB step
    localparam logic [16:0] TRIM_GAIN [0:10] = '{
        17'h08000, 17'h080BD, 17'h0817C, 17'h0823B, 17'h082FC, 17'h083BD,
        17'h08480, 17'h08544, 17'h08609, 17'h086CF, 17'h08796
    };

    typedef logic [NUM_TAPS-1:0][SAMPLE_W-1:0] tap_line_t;
    typedef logic [NUM_TAPS-1:0][COEF_W-1:0] coef_set_t;

    // built-in coefficient set, Q2.10, a plain four-tap average by default
    localparam coef_set_t BUILTIN_COEFS = {
        {10{12'h000}}, {4{12'h100}}, {10{12'h000}}
    };

    // one sample of each channel travelling together
    typedef struct packed {
        logic [SAMPLE_W-1:0] chA;
        logic [SAMPLE_W-1:0] chB;
    } sample_pair_t;

    // configuration write/read request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_t;

endpackage

`default_nettype wire

// ==== fir_dot_product.sv ====
// combinational multiply-accumulate over one channel's tap line
`timescale 1ns/1ps
`default_nettype none

module fir_dot_product (
    input var adc_dsp_pkg::tap_line_t taps, // newest sample at index 0
    input var adc_dsp_pkg::coef_set_t coefs, // signed Q2.10 coefficients
    input wire logic oddTaps, // drop the last tap when set
    output logic signed [adc_dsp_pkg::FIR_SUM_W-1:0] sum // full precision result
);
    import adc_dsp_pkg::*;

    // sum of products; widened before multiplying so no product is clipped
    always_comb
    begin
        sum = '0;
        for (int i = 0; i < NUM_TAPS; i++)
        begin
            if (!(oddTaps && i == NUM_TAPS - 1))
            begin
                sum = sum + (FIR_SUM_W'(signed'(taps[i])) * FIR_SUM_W'(signed'(coefs[i])));
            end
        end
    end

endmodule

`default_nettype wire

// ==== adc_processing_ctrl.sv ====
// dual-channel output processing path: offset removal, fine gain, filter, decimation
`timescale 1ns/1ps
`default_nettype none

module adc_processing_ctrl (
    input wire logic clk, // 200 MHz sample clock
    input wire logic reset_n, // synchronous reset, active low
    input var adc_dsp_pkg::reg_req_t regReq, // configuration access
    output logic [7:0] regRdData, // read data, registered
    input var adc_dsp_pkg::coef_set_t userCoefs, // user-written coefficient set
    input var adc_dsp_pkg::sample_pair_t samplesIn, // one sample per clock from the core
    output var adc_dsp_pkg::sample_pair_t samplesOut, // processed samples, registered
    output logic outValid // high in cycles that carry a kept sample
);
    import adc_dsp_pkg::*;

    // complete state of the block
    typedef struct packed {
        logic bypassFastPath; // fast path around everything
        logic [2:0] dcRemovalWindow; // averaging window code
        logic [3:0] fineTrimStep; // fine gain code
        logic dcRemovalOn; // offset correction enable
        logic coefSourceSel; // 0 built-in, 1 user coefficients
        logic firActive; // digital filter enable
        logic tapParitySel; // 0 even 24 taps, 1 odd 23 taps
        logic [2:0] downsampleFactor; // decimation code
        logic [DC_ACC_W-1:0] accA; // running mean of channel a, scaled up
        logic [DC_ACC_W-1:0] accB; // running mean of channel b, scaled up
        sample_pair_t dcOut; // after offset removal
        sample_pair_t gainOut; // after fine gain
        tap_line_t tapsA; // filter delay line, channel a
        tap_line_t tapsB; // filter delay line, channel b
        sample_pair_t firOut; // filter result
        logic firValid; // firOut is a kept sample
        logic [2:0] decCount; // position within the decimation group
        logic [LOW_LAT_DEPTH-1:0][2*SAMPLE_W-1:0] fastLine; // fast path delay line
        sample_pair_t outSample; // output register
        logic outValidBit; // output valid register
        logic [7:0] rdData; // read data register
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic signed [FIR_SUM_W-1:0] firSumA; // raw filter sum, channel a
    logic signed [FIR_SUM_W-1:0] firSumB; // raw filter sum, channel b
    coef_set_t activeCoefs; // coefficient set in use
    logic forceUser; // decimation code that has no built-in set

    // clip a wide signed value to the sample width
    function automatic logic [SAMPLE_W-1:0] sat14(input logic signed [47:0] v);
        logic signed [47:0] hi;
        logic signed [47:0] lo;
        hi = 48'sh000000001FFF;
        lo = -48'sh000000002000;
        if (v > hi)
            sat14 = 14'h1FFF;
        else if (v < lo)
            sat14 = 14'h2000;
        else
            sat14 = v[SAMPLE_W-1:0];
    endfunction

    // averaging exponent for each window code; 111 is never stored
    function automatic logic [4:0] dcShift(input logic [2:0] code);
        case (code)
            3'h0: dcShift = DC_SHIFT_27;
            3'h1: dcShift = DC_SHIFT_26;
            3'h2: dcShift = DC_SHIFT_25;
            3'h3: dcShift = DC_SHIFT_24;
            3'h4: dcShift = DC_SHIFT_28;
            3'h5: dcShift = DC_SHIFT_29;
            default: dcShift = DC_SHIFT_27;
        endcase
    endfunction

    // decimation group length minus one
    function automatic logic [2:0] decLast(input logic [2:0] code);
        case (code)
            DEC_BY_2: decLast = 3'h1;
            DEC_BY_4: decLast = 3'h3;
            DEC_BY_8: decLast = 3'h7;
            default: decLast = 3'h0; // no decimation
        endcase
    endfunction

    // a downsample code is taken only if it is one of the four defined ones
    function automatic logic decDefined(input logic [2:0] code);
        decDefined = (code == DEC_BY_2) || (code == DEC_BY_4) ||
                     (code == DEC_NONE) || (code == DEC_BY_8);
    endfunction

    // offset removal for one channel; returns corrected sample and next mean
    function automatic logic [SAMPLE_W+DC_ACC_W-1:0] dcStep(
        input logic [SAMPLE_W-1:0] x,
        input logic [DC_ACC_W-1:0] acc,
        input logic [4:0] shift,
        input logic on
    );
        logic signed [47:0] xWide;
        logic signed [47:0] mean;
        logic signed [47:0] diff;
        logic [SAMPLE_W-1:0] y;
        logic [DC_ACC_W-1:0] accNew;
        xWide = 48'(signed'(x));
        mean = 48'(signed'(acc) >>> shift);
        diff = xWide - mean;
        if (on)
        begin
            y = sat14(diff);
            accNew = acc + DC_ACC_W'(diff);
        end
        else
        begin
            // held at zero so a later enable starts from a clean mean
            y = x;
            accNew = '0;
        end
        dcStep = {y, accNew};
    endfunction

    // fine gain for one channel, common code for both channels
    function automatic logic [SAMPLE_W-1:0] trimGain(
        input logic [SAMPLE_W-1:0] x,
        input logic [3:0] code
    );
        logic signed [47:0] prod;
        prod = 48'(signed'(x)) * 48'(signed'({1'b0, TRIM_GAIN[code]}));
        trimGain = sat14(prod >>> GAIN_FRAC);
    endfunction

    // by-8 and no-decimation have no built-in set, so user coefficients win
    assign forceUser = (state_reg.downsampleFactor == DEC_NONE) ||
                       (state_reg.downsampleFactor == DEC_BY_8);
    assign activeCoefs = (state_reg.coefSourceSel || forceUser) ? userCoefs
                                                                 : BUILTIN_COEFS;

    // filter arithmetic, one per channel
    fir_dot_product firA (
        .taps(state_reg.tapsA),
        .coefs(activeCoefs),
        .oddTaps(state_reg.tapParitySel),
        .sum(firSumA)
    );

    fir_dot_product firB (
        .taps(state_reg.tapsB),
        .coefs(activeCoefs),
        .oddTaps(state_reg.tapParitySel),
        .sum(firSumB)
    );

    // next-state logic for registers, datapath and output
    always_comb
    begin
        logic [SAMPLE_W+DC_ACC_W-1:0] stepA;
        logic [SAMPLE_W+DC_ACC_W-1:0] stepB;
        logic [4:0] shift;
        stepA = '0;
        stepB = '0;
        state_next = state_reg;
        shift = dcShift(state_reg.dcRemovalWindow);

        // register writes; undefined codes leave the field unchanged
        if (regReq.wrEn && regReq.addr == ADDR_GAIN_OFFSET_LATENCY)
        begin
            state_next.bypassFastPath = regReq.wrData[BYPASS_FAST_PATH_BIT];
            if (regReq.wrData[DC_WINDOW_MSB:DC_WINDOW_LSB] != 3'h7)
                state_next.dcRemovalWindow = regReq.wrData[DC_WINDOW_MSB:DC_WINDOW_LSB];
            if (regReq.wrData[FINE_TRIM_MSB:FINE_TRIM_LSB] <= FINE_TRIM_MAX)
                state_next.fineTrimStep = regReq.wrData[FINE_TRIM_MSB:FINE_TRIM_LSB];
        end
        if (regReq.wrEn && regReq.addr == ADDR_FILTER_DECIMATION)
        begin
            state_next.dcRemovalOn = regReq.wrData[DC_REMOVAL_ON_BIT];
            state_next.coefSourceSel = regReq.wrData[COEF_SOURCE_BIT];
            state_next.firActive = regReq.wrData[FIR_ACTIVE_BIT];
            state_next.tapParitySel = regReq.wrData[TAP_PARITY_BIT];
            if (decDefined(regReq.wrData[DOWNSAMPLE_MSB:DOWNSAMPLE_LSB]))
                state_next.downsampleFactor = regReq.wrData[DOWNSAMPLE_MSB:DOWNSAMPLE_LSB];
        end

        // register reads show the stored fields; unmapped addresses read zero
        if (regReq.rdEn)
        begin
            case (regReq.addr)
                ADDR_GAIN_OFFSET_LATENCY:
                    state_next.rdData = {state_reg.bypassFastPath, state_reg.dcRemovalWindow,
                                         state_reg.fineTrimStep};
                ADDR_FILTER_DECIMATION:
                    state_next.rdData = {state_reg.dcRemovalOn, 1'b0, state_reg.coefSourceSel,
                                         state_reg.firActive, state_reg.tapParitySel,
                                         state_reg.downsampleFactor};
                default:
                    state_next.rdData = 8'h00;
            endcase
        end

        // offset removal stage
        stepA = dcStep(samplesIn.chA, state_reg.accA, shift, state_reg.dcRemovalOn);
        stepB = dcStep(samplesIn.chB, state_reg.accB, shift, state_reg.dcRemovalOn);
        state_next.dcOut.chA = stepA[SAMPLE_W+DC_ACC_W-1:DC_ACC_W];
        state_next.dcOut.chB = stepB[SAMPLE_W+DC_ACC_W-1:DC_ACC_W];
        state_next.accA = stepA[DC_ACC_W-1:0];
        state_next.accB = stepB[DC_ACC_W-1:0];

        // fine gain stage
        state_next.gainOut.chA = trimGain(state_reg.dcOut.chA, state_reg.fineTrimStep);
        state_next.gainOut.chB = trimGain(state_reg.dcOut.chB, state_reg.fineTrimStep);

        // filter delay lines shift every clock, newest at index 0
        state_next.tapsA = {state_reg.tapsA[NUM_TAPS-2:0], state_reg.gainOut.chA};
        state_next.tapsB = {state_reg.tapsB[NUM_TAPS-2:0], state_reg.gainOut.chB};

        // filter output and decimation; one sample kept per group
        state_next.firOut.chA = sat14(48'(firSumA >>> COEF_FRAC));
        state_next.firOut.chB = sat14(48'(firSumB >>> COEF_FRAC));
        state_next.firValid = (state_reg.decCount == 3'h0);
        if (state_reg.decCount >= decLast(state_reg.downsampleFactor))
            state_next.decCount = 3'h0;
        else
            state_next.decCount = state_reg.decCount + 3'h1;

        // fast path delay line, taps the raw converter samples
        state_next.fastLine = {state_reg.fastLine[LOW_LAT_DEPTH-2:0], samplesIn};

        // output selection; fast bypass takes priority over everything
        if (state_reg.bypassFastPath)
        begin
            state_next.outSample = state_reg.fastLine[LOW_LAT_DEPTH-1];
            state_next.outValidBit = 1'b1;
        end
        else if (state_reg.firActive)
        begin
            state_next.outSample = state_reg.firOut;
            state_next.outValidBit = state_reg.firValid;
        end
        else
        begin
            // filter bypassed: no decimation either
            state_next.outSample = state_reg.gainOut;
            state_next.outValidBit = 1'b1;
        end
    end

    // single state register; reset forces every field to a constant
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
            state_reg.fineTrimStep <= FINE_TRIM_RESET;
            state_reg.dcRemovalWindow <= DC_WINDOW_RESET;
            state_reg.dcRemovalOn <= 1'b0;
            state_reg.downsampleFactor <= DOWNSAMPLE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign samplesOut = state_reg.outSample;
    assign outValid = state_reg.outValidBit;
    assign regRdData = state_reg.rdData;

endmodule

`default_nettype wire

// ==== adc_processing_ctrl_assertions.sv ====
// concurrent checks on the ports of the adc output processing path
`timescale 1ns/1ps
`default_nettype none
module adc_processing_ctrl_assertions (
    input wire logic clk, // sample clock
    input wire logic reset_n, // synchronous reset, active low
    input var adc_dsp_pkg::reg_req_t regReq, // configuration access
    input wire logic [7:0] regRdData, // read data
    input var adc_dsp_pkg::coef_set_t userCoefs, // user coefficients
    input var adc_dsp_pkg::sample_pair_t samplesIn, // core samples
    input var adc_dsp_pkg::sample_pair_t samplesOut, // processed samples
    input wire logic outValid // kept-sample flag
);
    import adc_dsp_pkg::*;
    logic [7:0] gainReg; // shadow of gain_offset_latency_ctrl
    logic [7:0] filtReg; // shadow of filter_decimation_ctrl
    logic [4:0] ageReg; // edges since last write or reset, saturating
    logic [3:0] gapReg; // edges since the previous kept sample
    logic [7:0] rdExp; // what a read taken now must return
    logic [3:0] decGap; // expected spacing of kept samples
    assign rdExp = (regReq.addr == ADDR_GAIN_OFFSET_LATENCY) ? gainReg :
        (regReq.addr == ADDR_FILTER_DECIMATION) ? filtReg : 8'h00;
    assign decGap = (filtReg[2:0] == DEC_BY_2) ? 4'h2 : (filtReg[2:0] == DEC_BY_4) ? 4'h4 :
        (filtReg[2:0] == DEC_BY_8) ? 4'h8 : 4'h1;
    // shadow registers keep only what a write may change; undefined codes leave a field
    always_ff @(posedge clk)
    begin
        gapReg <= outValid ? 4'h1 : gapReg + {3'h0, gapReg != 4'hF};
        if (!reset_n)
        begin
            gainReg <= 8'h00;
            filtReg <= 8'h00;
            ageReg <= 5'h00;
        end
        else if (regReq.wrEn)
        begin
            ageReg <= 5'h00;
            if (regReq.addr == ADDR_GAIN_OFFSET_LATENCY)
            begin
                gainReg[7] <= regReq.wrData[7];
                if (regReq.wrData[6:4] != 3'h7) gainReg[6:4] <= regReq.wrData[6:4];
                if (regReq.wrData[3:0] <= FINE_TRIM_MAX) gainReg[3:0] <= regReq.wrData[3:0];
            end
            if (regReq.addr == ADDR_FILTER_DECIMATION)
            begin
                filtReg[7:3] <= {regReq.wrData[7], 1'b0, regReq.wrData[5:3]};
                if (regReq.wrData[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4})
                    filtReg[2:0] <= regReq.wrData[2:0];
            end
        end
        else if (ageReg != 5'h1F)
        begin
            ageReg <= ageReg + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // filter running long enough for its decimation pattern to settle
    sequence s_filt_settled;
        ageReg >= 5'd20 && !gainReg[7] && filtReg[4];
    endsequence
    property p_reset_clears;
        disable iff (1'b0) !reset_n |=> !outValid && samplesOut == '0 && regRdData == 8'h00;
    endproperty
    property p_read_data;
        regReq.rdEn |=> regRdData == $past(rdExp);
    endproperty
    property p_read_holds;
        !regReq.rdEn |=> $stable(regRdData);
    endproperty
    property p_bypass_latency;
        ageReg >= 5'd12 && gainReg[7] |-> outValid && samplesOut == $past(samplesIn, 10);
    endproperty
    property p_plain_path;
        ageReg >= 5'd6 && gainReg[7] == 1'b0 && gainReg[3:0] == 4'h0 && filtReg[7] == 1'b0
            && filtReg[4] == 1'b0 |-> samplesOut == $past(samplesIn, 3);
    endproperty
    property p_unfiltered_valid;
        ageReg >= 5'd12 && (gainReg[7] || !filtReg[4]) |-> outValid;
    endproperty
    property p_decim_gap;
        s_filt_settled ##0 outValid |-> gapReg == decGap;
    endproperty
    property p_decim_live;
        s_filt_settled |-> ##[0:7] outValid;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("outputs not cleared by reset");
    a_read_data: assert property (p_read_data)
        else $error("read data wrong");
    a_read_holds: assert property (p_read_holds)
        else $error("read data moved without a read");
    a_bypass_latency: assert property (p_bypass_latency)
        else $error("fast bypass latency wrong");
    a_plain_path: assert property (p_plain_path)
        else $error("unprocessed path altered samples");
    a_unfiltered_valid: assert property (p_unfiltered_valid)
        else $error("kept flag low with filter off");
    a_decim_gap: assert property (p_decim_gap)
        else $error("kept sample spacing wrong");
    a_decim_live: assert property (p_decim_live)
        else $error("no kept sample in eight cycles");
endmodule
`default_nettype wire

// ==== reg_host_model.sv ====
// host-side model that programs the configuration registers
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
    input wire logic clk, // sample clock
    input wire logic [7:0] regRdData, // read data from the block
    output var adc_dsp_pkg::reg_req_t regReq // configuration access
);
    import adc_dsp_pkg::*;
    // idle with strobes low from time zero
    initial regReq = '0;
    // drop strobes; stale address and data are inverted so they never look held
    task automatic release_bus();
        regReq.wrEn = 1'b0;
        regReq.rdEn = 1'b0;
        regReq.addr = ~regReq.addr;
        regReq.wrData = ~regReq.wrData;
    endtask
    // one-cycle write; undefined codes go out only when a refusal test asks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(negedge clk);
        release_bus();
    endtask
    // one-cycle read; the data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(negedge clk);
        d = regRdData;
        release_bus();
    endtask
endmodule
`default_nettype wire

// ==== adc_processing_ctrl_bench.sv ====
// self-checking bench for the adc output processing path
`timescale 1ns/1ps
`default_nettype none
module adc_processing_ctrl_bench;
    import adc_dsp_pkg::*;
    logic clk; // 200 MHz sample clock
    logic reset_n; // synchronous reset, active low
    reg_req_t regReq; // from the host model
    logic [7:0] regRdData; // read data
    coef_set_t userCoefs; // user coefficient set
    sample_pair_t samplesIn; // stimulus samples
    sample_pair_t samplesOut; // processed samples
    logic outValid; // kept-sample flag
    logic [7:0] rdVal; // last value read
    int n_mismatch = 0; // mismatches seen
    int checks = 0; // comparisons made
    int cycles = 0; // timeout count
    adc_processing_ctrl dut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
        .regRdData(regRdData), .userCoefs(userCoefs), .samplesIn(samplesIn),
        .samplesOut(samplesOut), .outValid(outValid));
    reg_host_model host (.clk(clk), .regRdData(regRdData), .regReq(regReq));
    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a hang counts as a mismatch and ends the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    // compare; near allows one code of rounding either way
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input bit near = 0);
        checks++;
        if (got !== exp && !(near && (got === exp + 16'h1 || got === exp - 16'h1)))
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rdVal);
        chk({8'h00, rdVal}, {8'h00, exp});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // reset values, unmapped place, and undefined codes that must leave fields alone
    task automatic t_fields();
        logic [2:0] keep;
        rd_chk(ADDR_GAIN_OFFSET_LATENCY, 8'h00); // trim zero after reset
        rd_chk(ADDR_FILTER_DECIMATION, 8'h00); // offset correction off
        host.wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00); // unmapped place reads zero
        keep = 3'h0;
        for (int c = 0; c < 8; c++)
        begin
            host.wr(ADDR_GAIN_OFFSET_LATENCY, {1'b0, 3'(c), 4'h0});
            keep = (c == 7) ? keep : 3'(c);
            rd_chk(ADDR_GAIN_OFFSET_LATENCY, {1'b0, keep, 4'h0}); // window codes
        end
        keep = 3'h0;
        for (int c = 0; c < 8; c++)
        begin
            host.wr(ADDR_FILTER_DECIMATION, {5'h08, 3'(c)});
            keep = (c inside {0, 1, 3, 4}) ? 3'(c) : keep;
            rd_chk(ADDR_FILTER_DECIMATION, {5'h00, keep}); // decimation codes
        end
        $display("done: fields");
    endtask
    // every trim code on a steady input, both channels
    task automatic t_trim();
        logic [3:0] code;
        logic [15:0] e;
        samplesIn = '{chA: 14'h1000, chB: 14'h3000};
        host.wr(ADDR_FILTER_DECIMATION, 8'h00);
        code = 4'h0;
        for (int c = 0; c < 12; c++)
        begin
            host.wr(ADDR_GAIN_OFFSET_LATENCY, 8'(c));
            code = (c > 10) ? code : 4'(c);
            rd_chk(ADDR_GAIN_OFFSET_LATENCY, {4'h0, code}); // code above ten ignored
            repeat (6) @(negedge clk);
            e = 16'($rtoi(4096.0 * 10.0 ** (code * 0.0025) + 0.5));
            chk({2'h0, samplesOut.chA}, e, 1); // 0.05 dB per code
            chk({2'h0, samplesOut.chB}, {2'h0, 14'(16'h0 - e)}, 1); // same gain
        end
        $display("done: trim");
    endtask
    // ramp through the path and look for it exactly lat edges later
    task automatic t_latency(input int lat, input logic [7:0] cfgA, input logic [7:0] cfgB);
        sample_pair_t hist [0:39];
        host.wr(ADDR_GAIN_OFFSET_LATENCY, cfgA);
        host.wr(ADDR_FILTER_DECIMATION, cfgB);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk);
            if (i >= lat)
            begin
                chk({2'h0, samplesOut.chA}, {2'h0, hist[i - lat].chA});
                chk({2'h0, samplesOut.chB}, {2'h0, hist[i - lat].chB});
            end
            hist[i] = '{chA: 14'(i * 37), chB: 14'(16'h3FFF - i)};
            samplesIn = hist[i];
        end
        $display("done: latency");
    endtask
    // coefficient source, forced user set, tap parity on a steady input
    task automatic t_filter();
        logic [7:0] cfg [0:5] = '{8'h10, 8'h30, 8'h13, 8'h14, 8'h30, 8'h38};
        logic [13:0] want [0:5] = '{14'h1000, 14'h0800, 14'h0800, 14'h0800, 14'h0800, 14'h0};
        int n;
        samplesIn = '{chA: 14'h1000, chB: 14'h3000};
        host.wr(ADDR_GAIN_OFFSET_LATENCY, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            userCoefs = '0;
            userCoefs[(i < 4) ? 0 : 23] = 12'h200;
            host.wr(ADDR_FILTER_DECIMATION, cfg[i]);
            repeat (40) @(negedge clk);
            n = 0;
            while (outValid !== 1'b1 && n < 16)
            begin
                @(negedge clk);
                n++;
            end
            chk({2'h0, samplesOut.chA}, {2'h0, want[i]});
            chk({2'h0, samplesOut.chB}, {2'h0, 14'h0 - want[i]});
        end
        $display("done: filter");
    endtask
    // kept samples per 64 cycles for every decimation code
    task automatic t_decim();
        logic [2:0] code [0:3] = '{DEC_BY_2, DEC_BY_4, DEC_NONE, DEC_BY_8};
        int want [0:3] = '{32, 16, 64, 8};
        int n;
        for (int i = 0; i < 4; i++)
        begin
            host.wr(ADDR_FILTER_DECIMATION, {5'h06, code[i]});
            repeat (24) @(negedge clk);
            n = 0;
            repeat (64)
            begin
                @(negedge clk);
                n += (outValid === 1'b1);
            end
            chk(16'(n), 16'(want[i]));
        end
        $display("done: decimation");
    endtask
    // offset correction on, shortest window: the mean reaches one code after about 2049 clocks
    task automatic t_offset();
        samplesIn = '{chA: 14'h1FFF, chB: 14'h2000};
        host.wr(ADDR_GAIN_OFFSET_LATENCY, 8'h30);
        host.wr(ADDR_FILTER_DECIMATION, 8'h80);
        repeat (2200) @(negedge clk);
        chk({2'h0, samplesOut.chA}, 16'h1FFE); // mean of one removed
        chk({2'h0, samplesOut.chB}, 16'h2002); // mean of minus two removed
        $display("done: offset");
    endtask
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        userCoefs = '0;
        samplesIn = '0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_fields();
        t_trim();
        t_latency(10, 8'h8A, 8'h93); // bypass overrides all
        t_latency(3, 8'h00, 8'h00); // unprocessed path
        t_filter();
        t_decim();
        t_offset();
        stop_test();
    end
endmodule
bind adc_processing_ctrl adc_processing_ctrl_assertions checker_i (.clk(clk),
    .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData), .userCoefs(userCoefs),
    .samplesIn(samplesIn), .samplesOut(samplesOut), .outValid(outValid));
`default_nettype wire
